// ### bench/air_peer_model.sv
// Remote radio: free running link clock, frame sender and catcher
`timescale 1ns/1ps
module air_peer_model (
	// Link toward the engine
	output logic      air_clk,
	output logic      air_din,
	input  wire logic air_dout,
	input  wire logic air_dout_en
);
	logic [88:0] cap;
	logic [88:0] got;
	logic        ack_on;
	int          frames;
	function automatic logic [7:0] crc8(input logic [72:0] b);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 72; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	// Bits change on falling link edges; idle holds inverse of last bit
	task automatic send_frame(input logic [39:0] a, input logic t, input logic [31:0] p);
		logic [88:0] f;
		f = {8'hAA, a, t, p, crc8({a, t, p})};
		for (int i = 88; i >= 0; i--)
		begin
			@(negedge air_clk);
			air_din <= f[i];
		end
		@(negedge air_clk);
		air_din <= ~f[0];
	endtask : send_frame
	initial
	begin
		air_clk = 1'b0;
		air_din = 1'b1;
		ack_on = 1'b0;
		frames = 0;
		cap = '0;
		forever #62.5 air_clk = ~air_clk;
	end
	always @(negedge air_clk)
		if (air_dout_en)
			cap <= {cap[87:0], air_dout};
	always @(negedge air_dout_en)
		if ($time > 0)
		begin
			#1;
			got = cap;
			frames++;
			if (ack_on && !got[40])
				send_frame(got[80:41], 1'b1, 32'h0);
		end
endmodule : air_peer_model

// ### bench/auto_ack_packet_engine_bench.sv
// Self-checking bench for the packet engine
`timescale 1ns/1ps
`include "pkt_engine_defs.svh"
module auto_ack_packet_engine_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ev;
	logic        air_clk, air_din, air_dout, air_dout_en;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [39:0] pa [4];
	int          miscompares = 0;
	int          check_count = 0;
	auto_ack_packet_engine #(.ACK_WAIT_BITS(120)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .air_clk(air_clk),
		.air_din(air_din), .air_dout(air_dout), .air_dout_en(air_dout_en));
	air_peer_model u_peer (.air_clk(air_clk), .air_din(air_din), .air_dout(air_dout),
		.air_dout_en(air_dout_en));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic timeout();
		miscompares++;
		close_out();
	endtask : timeout
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		{rv, ev} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (n == 50)
			timeout();
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(e, rv);
	endtask : rd
	task automatic poll(input logic [31:0] m);
		int n;
		n = 0;
		apb(1'b0, `OFF_STATUS, 32'h0);
		while ((rv & m) !== m && n < 3000)
		begin
			apb(1'b0, `OFF_STATUS, 32'h0);
			n++;
		end
		if (n == 3000)
			timeout();
	endtask : poll
	task automatic chk_frame(input logic [39:0] a, input logic t, input logic [31:0] p);
		chk(32'hAA, {24'h0, u_peer.got[88:81]});
		chk(a[39:8], u_peer.got[80:49]);
		chk({23'h0, a[7:0], t}, {23'h0, u_peer.got[48:40]});
		chk(p, u_peer.got[39:8]);
		chk({24'h0, u_peer.crc8({a, t, p})}, {24'h0, u_peer.got[7:0]});
	endtask : chk_frame
	task automatic t_reset();
		rd(`OFF_RETRY, 32'h3);
		wr(`OFF_STATUS, 32'hFFFFFFFF);
		rd(`OFF_STATUS, 32'h1B8);
		rd(8'h40, 32'h0);
		chk({31'h0, ev}, 32'h1);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_tx_ack();
		u_peer.ack_on = 1'b1;
		wr(`OFF_TX_ADDR_LO, 32'hC0DE1234);
		wr(`OFF_TX_ADDR_HI, 32'h5A);
		wr(`OFF_P0_ADDR_LO, 32'hC0DE1234);
		wr(`OFF_P0_ADDR_HI, 32'h5A);
		wr(`OFF_IRQ_EN, 32'h7);
		for (int i = 0; i < 4; i++)
			wr(`OFF_TX_FIFO, 32'h10000000 + i);
		rd(`OFF_STATUS, 32'h178);
		wr(`OFF_CTRL, 32'h2);
		poll(32'h80);
		chk(32'd3, u_peer.frames);
		chk_frame(40'h5AC0DE1234, 1'b0, 32'h10000002);
		rd(`OFF_STATUS, 32'h1BA);
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_CLR, 32'h2);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		$display("t_tx_ack done");
	endtask : t_tx_ack
	task automatic t_retry();
		u_peer.ack_on = 1'b0;
		wr(`OFF_RETRY, 32'h1);
		wr(`OFF_TX_FIFO, 32'hBEEF0001);
		poll(32'h4);
		chk(32'd5, u_peer.frames);
		rd(`OFF_RETRY, 32'h101);
		chk_frame(40'h5AC0DE1234, 1'b0, 32'hBEEF0001);
		chk({31'h0, irq}, 32'h1);
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_IRQ_CLR, 32'h7);
		rd(`OFF_STATUS, 32'h138);
		$display("t_retry done");
	endtask : t_retry
	task automatic t_rx();
		int f;
		pa = '{40'h5511223344, 40'hA1A2A3A403, 40'hA1A2A3A405, 40'hA1A2A3A401};
		wr(`OFF_P0_ADDR_LO, 32'h11223344);
		wr(`OFF_P0_ADDR_HI, 32'h55);
		wr(`OFF_PIPE_MSB, 32'hA1A2A3A4);
		wr(`OFF_PIPE_LSB_A, 32'h04030201);
		wr(`OFF_PIPE_LSB_B, 32'h05);
		wr(`OFF_CTRL, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			f = u_peer.frames;
			u_peer.send_frame(pa[k], 1'b0, 32'hD0 + k);
			for (int n = 0; n < 3000 && u_peer.frames == f && k < 3; n++)
				@(posedge pclk);
			repeat (200) @(posedge pclk);
			chk(u_peer.frames, f + (k < 3));
			if (k < 3)
				chk_frame(pa[k], 1'b1, 32'h0);
		end
		rd(`OFF_STATUS, 32'h201);
		wr(`OFF_IRQ_EN, 32'h0);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		wr(`OFF_IRQ_EN, 32'h7);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b0, `OFF_STATUS, 32'h0);
			chk((k == 0) ? 32'h0 : {29'h0, pa[k][2:0]}, {29'h0, rv[5:3]});
			rd(`OFF_RX_FIFO, 32'hD0 + k);
		end
		rd(`OFF_RX_FIFO, 32'h0);
		wr(`OFF_IRQ_CLR, 32'h7);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		$display("t_rx done");
	endtask : t_rx
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_tx_ack();
		t_retry();
		t_rx();
		close_out();
	end
endmodule : auto_ack_packet_engine_bench
bind auto_ack_packet_engine engine_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .air_clk(air_clk),
	.air_din(air_din), .air_dout(air_dout), .air_dout_en(air_dout_en));

// ### bench/auto_ack_packet_engine_sva.sv
// Port checker for the packet engine
`timescale 1ns/1ps
`include "pkt_engine_defs.svh"
module engine_checker (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt and link
	input wire logic        irq,
	input wire logic        air_clk,
	input wire logic        air_din,
	input wire logic        air_dout,
	input wire logic        air_dout_en
);
	logic [2:0] sync_reg;
	logic [6:0] cnt_reg;
	logic [6:0] cnt_next;
	logic       clr_hit;
	assign clr_hit = psel && penable && pready && pwrite
		&& (paddr == `OFF_IRQ_CLR || paddr == `OFF_IRQ_EN);
	// Link edges seen while a frame is driven
	always_comb
		cnt_next = air_dout_en ? cnt_reg + 7'(sync_reg[1] && !sync_reg[2]) : 7'h00;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{sync_reg, cnt_reg} <= '0;
		else
			{sync_reg, cnt_reg} <= {sync_reg[1:0], air_clk, cnt_next};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_first_access;
		psel && penable && !$past(penable);
	endsequence
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	a_ready_one_wait: assert property (s_first_access |-> s_one_wait)
		else $error("pready not in second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable && $past(penable))
		else $error("pready outside an access phase");
	a_err_unmapped: assert property (pready && paddr > `OFF_RX_FIFO |-> pslverr)
		else $error("unmapped access without error");
	a_err_fifo_ok: assert property (pready && paddr == `OFF_TX_FIFO |-> !pslverr)
		else $error("fifo access refused");
	a_unmapped_zero: assert property (pready && !pwrite && paddr > `OFF_RX_FIFO |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_fall_clear: assert property ($fell(irq) |-> $past(clr_hit))
		else $error("irq fell without clear or mask");
	a_frame_length: assert property ($fell(air_dout_en) |-> cnt_reg >= 7'h58 && cnt_reg <= 7'h5A)
		else $error("frame length wrong");
endmodule : engine_checker

// ### design/auto_ack_packet_engine.sv
// Auto acknowledge packet engine with APB registers and serial air link
`timescale 1ns/1ps
`include "pkt_engine_defs.svh"

module auto_ack_packet_engine #(
	parameter int TX_DEPTH      = 3,
	parameter int RX_DEPTH      = 3,
	parameter int ACK_WAIT_BITS = `ACK_WAIT_BITS
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Air link
	input  wire logic        air_clk,
	input  wire logic        air_din,
	output logic             air_dout,
	output logic             air_dout_en
);

	localparam int CW = 3;

	if (TX_DEPTH < 1 || TX_DEPTH > 7) $error("TX_DEPTH must be 1..7");
	if (RX_DEPTH < 1 || RX_DEPTH > 7) $error("RX_DEPTH must be 1..7");
	if (ACK_WAIT_BITS < 2 || ACK_WAIT_BITS > 65535) $error("ACK_WAIT_BITS out of range");

	typedef struct packed {
		logic [2:0]                   clk_sync;
		logic [1:0]                   din_sync;
		logic                         role_rx;
		logic                         tx_en;
		logic [2:0]                   flags;
		logic [2:0]                   irq_en;
		logic [3:0]                   retry_limit;
		logic [39:0]                  tx_addr;
		logic [39:0]                  p0_addr;
		logic [31:0]                  pipe_msb;
		logic [39:0]                  pipe_lsb;
		logic [TX_DEPTH-1:0][31:0]    txf;
		logic [CW-1:0]                tx_cnt;
		logic [RX_DEPTH-1:0][34:0]    rxf;
		logic [CW-1:0]                rx_cnt;
		pkt_engine_pkg::link_state_e  link;
		logic                         sending_ack;
		logic [88:0]                  tx_shift;
		logic [6:0]                   bit_cnt;
		logic [3:0]                   retries;
		logic [15:0]                  wait_cnt;
		logic                         rx_active;
		logic [7:0]                   hunt;
		logic [80:0]                  rx_buf;
		logic [6:0]                   rx_left;
		logic                         pending_ack;
		logic [39:0]                  ack_addr;
		logic                         pready;
		logic [31:0]                  prdata;
		logic                         pslverr;
		logic                         pop_ok;
		logic                         irq;
		logic                         air_dout;
		logic                         air_dout_en;
	} state_s;

	state_s s_reg;
	state_s s_next;

	function automatic logic [7:0] crc8(input logic [72:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 72; i >= 0; i--)
		begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8

	// Preamble, address, type, payload, CRC
	function automatic logic [88:0] make_frame(input logic [39:0] a, input logic t,
		input logic [31:0] p);
		return {`PREAMBLE, a, t, p, crc8({a, t, p})};
	endfunction : make_frame

	logic        lk;
	logic        bit_in;
	logic        setup_acc;
	logic        acc;
	logic [2:0]  set_f;
	logic [2:0]  clr_f;
	logic        tx_push;
	logic        tx_pop;
	logic        rx_push;
	logic        rx_pop;
	logic [34:0] rx_word;
	logic        ack_got;
	logic [80:0] fr;
	logic        crc_ok;
	logic        hit;
	logic [2:0]  pnum;
	logic [31:0] rd;
	logic        err;

	always_comb
	begin
		s_next = s_reg;
		s_next.clk_sync = {s_reg.clk_sync[1:0], air_clk};
		s_next.din_sync = {s_reg.din_sync[0], air_din};
		lk = s_reg.clk_sync[1] & ~s_reg.clk_sync[2];
		bit_in = s_reg.din_sync[1];
		set_f = 3'h0;
		clr_f = 3'h0;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_word = 35'h0;
		ack_got = 1'b0;
		fr = {s_reg.rx_buf[79:0], bit_in};
		crc_ok = (crc8(fr[80:8]) == fr[7:0]);
		hit = 1'b0;
		pnum = `PIPE_NONE;
		rd = 32'h0;
		err = 1'b0;

		// Pipe match, pipe zero checked last so it wins
		for (int k = 1; k <= 5; k++)
		begin
			if (fr[80:41] == {s_reg.pipe_msb, s_reg.pipe_lsb[8*k-1 -: 8]})
			begin
				hit = 1'b1;
				pnum = 3'(k);
			end
		end
		if (fr[80:41] == s_reg.p0_addr)
		begin
			hit = 1'b1;
			pnum = 3'h0;
		end

		// APB: one wait cycle, read data captured then
		setup_acc = psel & penable & ~s_reg.pready;
		acc = psel & penable & s_reg.pready;
		s_next.pready = setup_acc;
		if (setup_acc)
		begin
			case (paddr)
				`OFF_CTRL:       rd = {30'h0, s_reg.tx_en, s_reg.role_rx};
				`OFF_STATUS:     rd = {22'h0, s_reg.rx_cnt == CW'(RX_DEPTH), s_reg.rx_cnt == 0,
					s_reg.tx_cnt == 0, s_reg.tx_cnt == CW'(TX_DEPTH),
					(s_reg.rx_cnt == 0) ? `PIPE_NONE : s_reg.rxf[0][34:32], s_reg.flags};
				`OFF_IRQ_CLR:    rd = 32'h0;
				`OFF_IRQ_EN:     rd = {29'h0, s_reg.irq_en};
				`OFF_RETRY:      rd = {20'h0, s_reg.retries, 4'h0, s_reg.retry_limit};
				`OFF_TX_ADDR_LO: rd = s_reg.tx_addr[31:0];
				`OFF_TX_ADDR_HI: rd = {24'h0, s_reg.tx_addr[39:32]};
				`OFF_P0_ADDR_LO: rd = s_reg.p0_addr[31:0];
				`OFF_P0_ADDR_HI: rd = {24'h0, s_reg.p0_addr[39:32]};
				`OFF_PIPE_MSB:   rd = s_reg.pipe_msb;
				`OFF_PIPE_LSB_A: rd = s_reg.pipe_lsb[31:0];
				`OFF_PIPE_LSB_B: rd = {24'h0, s_reg.pipe_lsb[39:32]};
				`OFF_TX_FIFO:    rd = 32'h0;
				`OFF_RX_FIFO:    rd = (s_reg.rx_cnt == 0) ? 32'h0 : s_reg.rxf[0][31:0];
				default:         err = 1'b1;
			endcase
			s_next.prdata = pwrite ? 32'h0 : rd;
			s_next.pslverr = err;
			s_next.pop_ok = ~pwrite & (paddr == `OFF_RX_FIFO) & (s_reg.rx_cnt != 0);
		end
		else if (acc)
		begin
			s_next.pslverr = 1'b0;
		end

		if (acc && pwrite)
		begin
			case (paddr)
				`OFF_CTRL:
				begin
					s_next.role_rx = pwdata[`CTRL_ROLE_RX];
					s_next.tx_en = pwdata[`CTRL_TX_EN];
				end
				`OFF_IRQ_CLR:    clr_f = pwdata[2:0];
				`OFF_IRQ_EN:     s_next.irq_en = pwdata[2:0];
				`OFF_RETRY:      s_next.retry_limit = pwdata[3:0];
				`OFF_TX_ADDR_LO: s_next.tx_addr[31:0] = pwdata;
				`OFF_TX_ADDR_HI: s_next.tx_addr[39:32] = pwdata[7:0];
				`OFF_P0_ADDR_LO: s_next.p0_addr[31:0] = pwdata;
				`OFF_P0_ADDR_HI: s_next.p0_addr[39:32] = pwdata[7:0];
				`OFF_PIPE_MSB:   s_next.pipe_msb = pwdata;
				`OFF_PIPE_LSB_A: s_next.pipe_lsb[31:0] = pwdata;
				`OFF_PIPE_LSB_B: s_next.pipe_lsb[39:32] = pwdata[7:0];
				`OFF_TX_FIFO:    tx_push = (s_reg.tx_cnt != CW'(TX_DEPTH));
				default:         tx_push = 1'b0;
			endcase
		end
		rx_pop = acc & ~pwrite & (paddr == `OFF_RX_FIFO) & s_reg.pop_ok;

		// Receiver, off only while a frame is being driven out
		if (lk && s_reg.link != pkt_engine_pkg::LINK_SEND)
		begin
			if (!s_reg.rx_active)
			begin
				s_next.hunt = {s_reg.hunt[6:0], bit_in};
				if (s_next.hunt == `PREAMBLE)
				begin
					s_next.rx_active = 1'b1;
					s_next.rx_left = `BODY_BITS;
				end
			end
			else
			begin
				s_next.rx_buf = fr;
				s_next.rx_left = s_reg.rx_left - 7'd1;
				if (s_reg.rx_left == 7'd1)
				begin
					s_next.rx_active = 1'b0;
					s_next.hunt = 8'h00;
					if (crc_ok && s_reg.role_rx && !fr[40] && hit
						&& s_reg.rx_cnt != CW'(RX_DEPTH))
					begin
						rx_push = 1'b1;
						rx_word = {pnum, fr[39:8]};
						set_f[`FLAG_RX_READY] = 1'b1;
						s_next.pending_ack = 1'b1;
						s_next.ack_addr = fr[80:41];
					end
					if (crc_ok && !s_reg.role_rx && fr[40] && fr[80:41] == s_reg.p0_addr
						&& s_reg.link == pkt_engine_pkg::LINK_WAIT_ACK)
					begin
						ack_got = 1'b1;
					end
				end
			end
		end

		// Link sequencer
		case (s_reg.link)
			pkt_engine_pkg::LINK_IDLE:
			begin
				if (s_reg.pending_ack)
				begin
					s_next.pending_ack = 1'b0;
					s_next.tx_shift = make_frame(s_reg.ack_addr, 1'b1, 32'h0);
					s_next.bit_cnt = `FRAME_BITS;
					s_next.sending_ack = 1'b1;
					s_next.air_dout_en = 1'b1;
					s_next.link = pkt_engine_pkg::LINK_SEND;
				end
				else if (!s_reg.role_rx && s_reg.tx_en && s_reg.tx_cnt != 0
					&& !s_reg.flags[`FLAG_RETRY_LIM])
				begin
					s_next.tx_shift = make_frame(s_reg.tx_addr, 1'b0, s_reg.txf[0]);
					s_next.bit_cnt = `FRAME_BITS;
					s_next.sending_ack = 1'b0;
					s_next.retries = 4'h0;
					s_next.air_dout_en = 1'b1;
					s_next.link = pkt_engine_pkg::LINK_SEND;
				end
			end
			pkt_engine_pkg::LINK_SEND:
			begin
				if (lk)
				begin
					if (s_reg.bit_cnt == 7'd0)
					begin
						s_next.air_dout_en = 1'b0;
						s_next.air_dout = 1'b0;
						s_next.wait_cnt = 16'h0;
						s_next.link = s_reg.sending_ack ? pkt_engine_pkg::LINK_IDLE
							: pkt_engine_pkg::LINK_WAIT_ACK;
					end
					else
					begin
						s_next.air_dout = s_reg.tx_shift[88];
						s_next.tx_shift = {s_reg.tx_shift[87:0], 1'b0};
						s_next.bit_cnt = s_reg.bit_cnt - 7'd1;
					end
				end
			end
			pkt_engine_pkg::LINK_WAIT_ACK:
			begin
				if (ack_got)
				begin
					tx_pop = 1'b1;
					set_f[`FLAG_TX_DONE] = 1'b1;
					s_next.link = pkt_engine_pkg::LINK_IDLE;
				end
				else if (lk)
				begin
					s_next.wait_cnt = s_reg.wait_cnt + 16'h1;
					if (s_reg.wait_cnt == 16'(ACK_WAIT_BITS - 1))
					begin
						if (s_reg.retries < s_reg.retry_limit)
						begin
							s_next.retries = s_reg.retries + 4'h1;
							s_next.tx_shift = make_frame(s_reg.tx_addr, 1'b0, s_reg.txf[0]);
							s_next.bit_cnt = `FRAME_BITS;
							s_next.air_dout_en = 1'b1;
							s_next.link = pkt_engine_pkg::LINK_SEND;
						end
						else
						begin
							set_f[`FLAG_RETRY_LIM] = 1'b1;
							s_next.link = pkt_engine_pkg::LINK_IDLE;
						end
					end
				end
			end
			default: s_next.link = pkt_engine_pkg::LINK_IDLE;
		endcase

		// FIFOs: pop first, then push at the new tail
		if (tx_pop)
		begin
			for (int i = 0; i < TX_DEPTH - 1; i++)
				s_next.txf[i] = s_reg.txf[i+1];
			s_next.txf[TX_DEPTH-1] = 32'h0;
		end
		s_next.tx_cnt = s_reg.tx_cnt - CW'(tx_pop);
		if (tx_push)
		begin
			s_next.txf[s_next.tx_cnt] = pwdata;
			s_next.tx_cnt = s_next.tx_cnt + CW'(1);
		end
		if (rx_pop)
		begin
			for (int i = 0; i < RX_DEPTH - 1; i++)
				s_next.rxf[i] = s_reg.rxf[i+1];
			s_next.rxf[RX_DEPTH-1] = 35'h0;
		end
		s_next.rx_cnt = s_reg.rx_cnt - CW'(rx_pop);
		if (rx_push)
		begin
			s_next.rxf[s_next.rx_cnt] = rx_word;
			s_next.rx_cnt = s_next.rx_cnt + CW'(1);
		end

		// Set wins over clear
		s_next.flags = (s_reg.flags & ~clr_f) | set_f;
		s_next.irq = |(s_next.flags & s_next.irq_en);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.retry_limit <= `RST_RETRY;
			s_reg.link <= pkt_engine_pkg::LINK_IDLE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;
	assign air_dout = s_reg.air_dout;
	assign air_dout_en = s_reg.air_dout_en;

endmodule : auto_ack_packet_engine

// ### pkg/pkt_engine_defs.svh
// Register offsets, field positions, reset values and frame constants
// What this block does
// - One three-entry receive FIFO shared by all six receive pipes.
// - A three-entry transmit FIFO holds payloads waiting to be sent.
// - Host reaches both FIFOs at any time, also while a frame is sent.
// - Interrupt when a valid addressed packet lands in the receive FIFO.
// - Preamble and CRC are added by the engine; host gives only payload.
// - Interrupt when a transmission has completed.
// - Receiver role listens on six pipes with unique addresses, tells them apart.
// - Pipe zero has a fully programmable 40-bit address.
// - Pipes one to five: own low byte, shared 32 upper address bits.
// - Acknowledge and retransmit automatically without the host.
// - Acknowledge goes out with the address the payload came in on.
// - Every pipe supports full auto acknowledge and retransmit.
// - Transmitter role sends each queued packet while transmit is enabled and the retry limit flag is clear.
// - After sending, receiver switches on and waits for an acknowledge.
// - No acknowledge: resend same packet until acked or retry limit passed.
// - Retry limit passed: set retry_limit_flag and raise an interrupt.
// - Acknowledge received: drop packet from transmit FIFO, set transmit_done_flag.
`ifndef PKT_ENGINE_DEFS_SVH
`define PKT_ENGINE_DEFS_SVH

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_IRQ_CLR     8'h08
`define OFF_IRQ_EN      8'h0C
`define OFF_RETRY       8'h10
`define OFF_TX_ADDR_LO  8'h14
`define OFF_TX_ADDR_HI  8'h18
`define OFF_P0_ADDR_LO  8'h1C
`define OFF_P0_ADDR_HI  8'h20
`define OFF_PIPE_MSB    8'h24
`define OFF_PIPE_LSB_A  8'h28
`define OFF_PIPE_LSB_B  8'h2C
`define OFF_TX_FIFO     8'h30
`define OFF_RX_FIFO     8'h34

`define CTRL_ROLE_RX    0
`define CTRL_TX_EN      1

`define FLAG_RX_READY   0
`define FLAG_TX_DONE    1
`define FLAG_RETRY_LIM  2
`define ST_PIPE_LSB     3
`define ST_TX_FULL      6
`define ST_TX_EMPTY     7
`define ST_RX_EMPTY     8
`define ST_RX_FULL      9
`define RETRY_USED_LSB  8

`define RST_RETRY       4'h3
`define PIPE_NONE       3'h7

`define PREAMBLE        8'hAA
`define CRC_POLY        8'h07
`define FRAME_BITS      7'd89
`define BODY_BITS       7'd81
`define ACK_WAIT_BITS   250

`endif

// ### pkg/pkt_engine_pkg.sv
// Types shared by the packet engine
package pkt_engine_pkg;

	typedef enum logic [1:0] {LINK_IDLE, LINK_SEND, LINK_WAIT_ACK} link_state_e;

endpackage : pkt_engine_pkg
